// ---- shared/fsps_regs.vh ----
// Register map, command codes and timing for the flash self-program sequencer
`ifndef FSPS_REGS_VH
`define FSPS_REGS_VH

// ==========================================================================
// Register byte offsets
`define FSPS_ADDR_CTRL      8'h00
`define FSPS_ADDR_POINTER   8'h04
`define FSPS_ADDR_DATA_LO   8'h08
`define FSPS_ADDR_DATA_HI   8'h0C
`define FSPS_ADDR_STATUS    8'h10

// ==========================================================================
// Control codes and fields
`define FSPS_CODE_ERASE     8'h03
`define FSPS_CODE_LOAD      8'h01
`define FSPS_CODE_WRITE     8'h05
`define FSPS_CODE_NONE      8'h00
`define FSPS_CTRL_REENABLE  4

// ==========================================================================
// Status fields
`define FSPS_STAT_BUSY      0
`define FSPS_STAT_PENDING   1
`define FSPS_STAT_BUF_USED  2
`define FSPS_STAT_EE_BLOCK  3
`define FSPS_STAT_ERASING   4
`define FSPS_STAT_WRITING   5

// ==========================================================================
// Timing
`define FSPS_SPM_WINDOW     3'h4
`define FSPS_OP_TIME_US     3700
`define FSPS_CLK_MHZ        250
// OP_TIME_US times CLK_MHZ, sized to the counter
`define FSPS_OP_CYCLES      24'hE1D48
`define FSPS_CNT_W          24

// ==========================================================================
// Reset values and the erased-word read value
`define FSPS_RST_BYTE       8'h00
`define FSPS_RST_WORD       16'h0000
`define FSPS_ERASED_WORD    16'hFFFF

`endif

// ---- design/fsps_page_buf.v ----
// Temporary page buffer with per-word loaded flags
`timescale 1ns/1ns
`default_nettype none
`include "fsps_regs.vh"

module fsps_page_buf #(
    parameter WORD_BITS = 5
) (
    input  wire                 clk,
    input  wire                 rst_n,
    input  wire                 clr,
    input  wire                 wr_en,
    input  wire [WORD_BITS-1:0] wr_idx,
    input  wire [15:0]          wr_data,
    input  wire [WORD_BITS-1:0] rd_idx,
    output wire [15:0]          rd_data,
    output wire                 any_used
);
    localparam DEPTH = 1 << WORD_BITS;

    reg [15:0]      mem_r [0:DEPTH-1];
    reg [DEPTH-1:0] used_r;

    // ======================================================================
    // Storage
    // Only the flags are reset; a word without its flag reads as erased
    always @(posedge clk) begin
        if (!rst_n) begin
            used_r <= {DEPTH{1'b0}}; // [R9]
        end else if (clr) begin
            // Clear and load in one cycle: the new word survives
            used_r <= wr_en ? ({{(DEPTH-1){1'b0}}, 1'b1} << wr_idx)
                            : {DEPTH{1'b0}}; // [R8]
        end else if (wr_en && !used_r[wr_idx]) begin
            used_r[wr_idx] <= 1'b1; // [R3]
        end
    end

    always @(posedge clk) begin
        if (wr_en && (clr || !used_r[wr_idx])) begin
            mem_r[wr_idx] <= wr_data; // [R2]
        end
    end

    assign rd_data  = used_r[rd_idx] ? mem_r[rd_idx] : `FSPS_ERASED_WORD;
    assign any_used = |used_r;
endmodule

`default_nettype wire

// ---- design/fsps_sequencer.v ----
// Flash self-program sequencer: command window, page buffer, erase and write
`timescale 1ns/1ns
`default_nettype none
`include "fsps_regs.vh"

// Summary of operation
// [R1] Flash changes whole pages; erase before write
// [R2] Buffer loads one word per store-program
// [R3] Buffer words load in any order
// [R4] Code 03 plus store-program within four cycles erases
// [R5] Erase ignores data and non-page pointer bits
// [R6] CPU halted throughout page erase
// [R7] Code 01 plus store-program loads data word
// [R8] Buffer clears after write and on re-enable
// [R9] Any system reset clears the buffer
// [R10] Software loads each word at most once
// [R11] EEPROM write during loading discards buffer
// [R12] Code 05 plus store-program writes page
// [R13] Software zeroes non-page pointer bits on write
// [R14] CPU halted throughout page write
// [R15] Software uses same page for erase, write
// [R16] Software preserves unchanged words itself
// [R17] Store-program accepted from any flash location
// [R18] Each operation lasts 3.7 to 4.5 ms
// [R19] EEPROM write blocks all programming commands
// [R20] No store-program in window clears code
// [R21] Other codes change neither flash nor buffer
module fsps_sequencer #(
    parameter WORD_BITS = 5,
    parameter PAGE_BITS = 6,
    parameter [`FSPS_CNT_W-1:0] OP_CYCLES = `FSPS_OP_CYCLES
) (
    input  wire                 clk,
    input  wire                 rst_n,
    input  wire [7:0]           avs_address,
    input  wire                 avs_read,
    input  wire                 avs_write,
    input  wire [31:0]          avs_writedata,
    input  wire [3:0]           avs_byteenable,
    output reg  [31:0]          avs_readdata,
    output reg                  avs_waitrequest,
    input  wire                 spm_exec,
    input  wire                 eeprom_busy,
    output reg                  cpu_halt_r,
    output reg                  flash_erase_r,
    output reg                  flash_prog_we_r,
    output reg  [PAGE_BITS-1:0] flash_page_r,
    output reg  [WORD_BITS-1:0] flash_word_r,
    output reg  [15:0]          flash_data_r
);
    localparam ST_IDLE   = 2'b00;
    localparam ST_STREAM = 2'b01;
    localparam ST_TIMING = 2'b10;
    localparam PTR_W     = WORD_BITS + PAGE_BITS + 1;
    localparam [WORD_BITS-1:0] LAST_WORD = {WORD_BITS{1'b1}};

    // ======================================================================
    // Pointer field decode
    function [WORD_BITS-1:0] word_of;
        input [15:0] ptr;
        begin
            word_of = ptr[WORD_BITS:1];
        end
    endfunction

    function [PAGE_BITS-1:0] page_of;
        input [15:0] ptr;
        begin
            page_of = ptr[PTR_W-1:WORD_BITS+1];
        end
    endfunction

    // ======================================================================
    // State
    reg [7:0]            ctrl_r;
    reg [15:0]           ptr_r;
    reg [7:0]            data_lo_r;
    reg [7:0]            data_hi_r;
    reg [2:0]            win_r;
    reg [1:0]            state_r;
    reg [1:0]            state_nxt;
    reg                  writing_r;
    reg [`FSPS_CNT_W-1:0] op_cnt_r;
    reg [WORD_BITS-1:0]  idx_r;
    reg                  ee_prev_r;
    reg                  avs_wr_ack;

    wire                 bus_req;
    wire                 bus_wr;
    wire                 bus_rd;
    wire                 ctrl_wr;
    wire                 reenable_wr;
    wire                 spm_go;
    wire                 do_erase;
    wire                 do_load;
    wire                 do_write;
    wire                 ee_rise;
    wire                 buf_clr;
    wire                 buf_any;
    wire [15:0]          buf_rd_data;
    wire [7:0]           status_w;
    wire [31:0]          rd_mux;

    // ======================================================================
    // Avalon slave: answer one cycle after the request is seen
    assign bus_req = (avs_read || avs_write) && avs_waitrequest && !avs_wr_ack;
    assign bus_wr  = bus_req && avs_write;
    assign bus_rd  = bus_req && avs_read;
    assign ctrl_wr = bus_wr && avs_address == `FSPS_ADDR_CTRL
                     && avs_byteenable[0];
    assign reenable_wr = ctrl_wr && avs_writedata[`FSPS_CTRL_REENABLE];

    assign status_w = {2'b00,
                       state_r != ST_IDLE && writing_r,
                       state_r != ST_IDLE && !writing_r,
                       eeprom_busy,
                       buf_any,
                       win_r != 3'h0,
                       state_r != ST_IDLE};

    assign rd_mux =
        (avs_address == `FSPS_ADDR_CTRL)    ? {24'h000000, ctrl_r}    :
        (avs_address == `FSPS_ADDR_POINTER) ? {16'h0000, ptr_r}       :
        (avs_address == `FSPS_ADDR_DATA_LO) ? {24'h000000, data_lo_r} :
        (avs_address == `FSPS_ADDR_DATA_HI) ? {24'h000000, data_hi_r} :
        (avs_address == `FSPS_ADDR_STATUS)  ? {24'h000000, status_w}  :
        32'h00000000;

    always @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_wr_ack      <= 1'b0;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_wr_ack      <= bus_req;
            avs_waitrequest <= !bus_req;
            if (bus_rd) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ======================================================================
    // Pointer and data registers
    always @(posedge clk) begin
        if (!rst_n) begin
            ptr_r     <= `FSPS_RST_WORD;
            data_lo_r <= `FSPS_RST_BYTE;
            data_hi_r <= `FSPS_RST_BYTE;
        end else if (bus_wr) begin
            if (avs_address == `FSPS_ADDR_POINTER) begin
                if (avs_byteenable[0]) begin
                    ptr_r[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    ptr_r[15:8] <= avs_writedata[15:8];
                end
            end
            if (avs_address == `FSPS_ADDR_DATA_LO && avs_byteenable[0]) begin
                data_lo_r <= avs_writedata[7:0];
            end
            if (avs_address == `FSPS_ADDR_DATA_HI && avs_byteenable[0]) begin
                data_hi_r <= avs_writedata[7:0];
            end
        end
    end

    // ======================================================================
    // Command window
    // The core may issue its store-program from any fetch address,
    // so no address qualifies spm_exec here
    assign spm_go   = spm_exec && win_r != 3'h0 && state_r == ST_IDLE
                      && !eeprom_busy; // [R17] [R19]
    assign do_erase = spm_go && ctrl_r == `FSPS_CODE_ERASE; // [R4]
    assign do_load  = spm_go && ctrl_r == `FSPS_CODE_LOAD;  // [R7]
    assign do_write = spm_go && ctrl_r == `FSPS_CODE_WRITE; // [R12]

    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= `FSPS_CODE_NONE;
            win_r  <= 3'h0;
        end else if (ctrl_wr) begin
            ctrl_r <= avs_writedata[7:0];
            win_r  <= `FSPS_SPM_WINDOW;
        end else if (spm_exec && win_r != 3'h0) begin
            // Consumed whether or not the code was valid
            ctrl_r <= `FSPS_CODE_NONE; // [R21]
            win_r  <= 3'h0;
        end else if (win_r == 3'h1) begin
            ctrl_r <= `FSPS_CODE_NONE; // [R20]
            win_r  <= 3'h0;
        end else if (win_r != 3'h0) begin
            win_r <= win_r - 3'h1;
        end
    end

    // ======================================================================
    // Temporary page buffer
    always @(posedge clk) begin
        if (!rst_n) begin
            ee_prev_r <= 1'b0;
        end else begin
            ee_prev_r <= eeprom_busy;
        end
    end

    assign ee_rise = eeprom_busy && !ee_prev_r;
    assign buf_clr = reenable_wr                        // [R8]
                     || (ee_rise && buf_any)            // [R11]
                     || (state_r == ST_TIMING && writing_r
                         && op_cnt_r == {`FSPS_CNT_W{1'b0}}); // [R8]

    fsps_page_buf #(
        .WORD_BITS (WORD_BITS)
    ) u_buf (
        .clk      (clk),
        .rst_n    (rst_n),
        .clr      (buf_clr),
        .wr_en    (do_load), // [R2]
        .wr_idx   (word_of(ptr_r)), // [R3]
        .wr_data  ({data_hi_r, data_lo_r}), // [R7]
        .rd_idx   (idx_r),
        .rd_data  (buf_rd_data),
        .any_used (buf_any)
    );

    // ======================================================================
    // Operation sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (do_write) begin
                    state_nxt = ST_STREAM;
                end else if (do_erase) begin
                    state_nxt = ST_TIMING;
                end
            end
            ST_STREAM: begin
                if (idx_r == LAST_WORD) begin
                    state_nxt = ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (op_cnt_r == {`FSPS_CNT_W{1'b0}}) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state_r         <= ST_IDLE;
            writing_r       <= 1'b0;
            op_cnt_r        <= {`FSPS_CNT_W{1'b0}};
            idx_r           <= {WORD_BITS{1'b0}};
            cpu_halt_r      <= 1'b0;
            flash_erase_r   <= 1'b0;
            flash_prog_we_r <= 1'b0;
            flash_page_r    <= {PAGE_BITS{1'b0}};
            flash_word_r    <= {WORD_BITS{1'b0}};
            flash_data_r    <= `FSPS_RST_WORD;
        end else begin
            state_r         <= state_nxt;
            flash_erase_r   <= 1'b0;
            flash_prog_we_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    idx_r <= {WORD_BITS{1'b0}};
                    // Full count minus one so the timing phase lasts OP_CYCLES
                    op_cnt_r <= OP_CYCLES - 1'b1; // [R18]
                    if (do_erase || do_write) begin
                        // Only the page field is used; data ignored
                        flash_page_r <= page_of(ptr_r); // [R5] [R1]
                        cpu_halt_r   <= 1'b1; // [R6] [R14]
                        writing_r    <= do_write;
                        flash_erase_r <= do_erase; // [R4]
                    end
                end
                ST_STREAM: begin
                    // Whole buffer goes out, so the page is whole
                    flash_prog_we_r <= 1'b1; // [R1] [R12]
                    flash_word_r    <= idx_r;
                    flash_data_r    <= buf_rd_data;
                    idx_r           <= idx_r + 1'b1;
                end
                ST_TIMING: begin
                    if (op_cnt_r == {`FSPS_CNT_W{1'b0}}) begin
                        cpu_halt_r <= 1'b0; // [R6] [R14]
                    end else begin
                        op_cnt_r <= op_cnt_r - 1'b1; // [R18]
                    end
                end
                default: begin
                    cpu_halt_r <= 1'b0;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// ---- verif/fsps_seq_props.sv ----
// Assertion checker for the flash self-program sequencer
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Checker
module fsps_seq_chk #(
    parameter int          WORD_BITS = 5,
    parameter logic [23:0] OP_CYCLES = 24'h14
) (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 spm_exec,
    input wire logic                 eeprom_busy,
    input wire logic                 cpu_halt_r,
    input wire logic                 flash_erase_r,
    input wire logic                 flash_prog_we_r,
    input wire logic [WORD_BITS-1:0] flash_word_r
);
    logic [31:0] hcnt_r;
    // Stall is far too long for a repetition, so count it
    always_ff @(posedge clk) begin
        hcnt_r <= (!rst_n || !cpu_halt_r) ? 32'h0 : hcnt_r + 32'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_halt_cause: assert property (
        $rose(cpu_halt_r) |-> $past(spm_exec) && !$past(eeprom_busy))
        else $error("stall began without an accepted store-program");
    chk_erase_halt: assert property (
        flash_erase_r |-> cpu_halt_r)
        else $error("erase pulse while the cpu runs");
    chk_prog_halt: assert property (
        flash_prog_we_r |-> cpu_halt_r)
        else $error("page programming while the cpu runs");
    chk_op_kind: assert property (
        $rose(cpu_halt_r) |-> flash_erase_r or (##1 flash_prog_we_r))
        else $error("stall without erase or write");
    chk_erase_once: assert property (
        flash_erase_r |=> !flash_erase_r)
        else $error("erase pulse longer than one cycle");
    chk_burst_start: assert property (
        $rose(flash_prog_we_r) |-> flash_word_r == '0 ##1
        flash_prog_we_r [*7])
        else $error("page write burst malformed");
    chk_word_step: assert property (
        flash_prog_we_r && $past(flash_prog_we_r) |->
        flash_word_r == $past(flash_word_r) + 1'b1)
        else $error("page write skipped a word");
    chk_halt_len: assert property (
        $fell(cpu_halt_r) |-> hcnt_r == OP_CYCLES ||
        hcnt_r == (1 << WORD_BITS) + OP_CYCLES)
        else $error("stall length wrong");
    cov_erase: cover property (flash_erase_r);
    cov_write: cover property ($rose(flash_prog_we_r));
    cov_ee_spm: cover property (spm_exec && eeprom_busy);
endmodule
bind fsps_sequencer fsps_seq_chk #(
    .WORD_BITS(WORD_BITS),
    .OP_CYCLES(OP_CYCLES)
) fsps_seq_chk_i (
    .clk(clk),
    .rst_n(rst_n),
    .spm_exec(spm_exec),
    .eeprom_busy(eeprom_busy),
    .cpu_halt_r(cpu_halt_r),
    .flash_erase_r(flash_erase_r),
    .flash_prog_we_r(flash_prog_we_r),
    .flash_word_r(flash_word_r)
);
`default_nettype wire

// ---- verif/fsps_cpu_model.sv ----
// CPU core model issuing store-program instructions
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Core model
module fsps_cpu_model (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       go,
    input wire logic [3:0] dly,
    input wire logic       halt,
    output logic           spm_exec
);
    logic [3:0] cnt_r;
    logic       arm_r;
    // A stalled core cannot execute, so countdown waits on halt
    always_ff @(posedge clk) begin
        spm_exec <= 1'b0;
        if (!rst_n) begin
            arm_r <= 1'b0;
        end else if (go && dly == 4'h0) begin
            // No delay asked: execute at once, one cycle after go
            spm_exec <= 1'b1;
        end else if (go) begin
            arm_r <= 1'b1;
            cnt_r <= dly - 4'h1;
        end else if (arm_r && !halt) begin
            if (cnt_r == 4'h0) begin
                spm_exec <= 1'b1;
                arm_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/tb_fsps_sequencer.sv ----
// Self-checking testbench for the flash self-program sequencer
`timescale 1ns/1ns
`default_nettype none
`include "fsps_regs.vh"
// ============================================================
// Bench
module tb_fsps_sequencer;
    logic        clk;
    logic        rst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        spm_exec;
    logic        eeprom_busy;
    logic        cpu_halt_r;
    logic        flash_erase_r;
    logic        flash_prog_we_r;
    logic [5:0]  flash_page_r;
    logic [4:0]  flash_word_r;
    logic [15:0] flash_data_r;
    logic        go;
    logic [3:0]  dly;
    logic [5:0]  er_page;
    logic [5:0]  wp_page;
    logic [15:0] seen [32];
    logic [31:0] q;
    int          fails;
    int          cmp_count;
    int          ne;
    int          nw;

    fsps_sequencer #(.OP_CYCLES(24'd20)) fsps_sequencer_i (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .spm_exec(spm_exec), .eeprom_busy(eeprom_busy),
        .cpu_halt_r(cpu_halt_r), .flash_erase_r(flash_erase_r),
        .flash_prog_we_r(flash_prog_we_r), .flash_page_r(flash_page_r),
        .flash_word_r(flash_word_r), .flash_data_r(flash_data_r));
    fsps_cpu_model fsps_cpu_model_i (.clk(clk), .rst_n(rst_n), .go(go),
        .dly(dly), .halt(cpu_halt_r), .spm_exec(spm_exec));

    // ========================================================
    // Flash side monitor
    always @(posedge clk) begin
        if (flash_erase_r) begin
            ne <= ne + 1;
            er_page <= flash_page_r;
        end
        if (flash_prog_we_r) begin
            nw <= nw + 1;
            wp_page <= flash_page_r;
            seen[flash_word_r] <= flash_data_r;
        end
    end

    // ========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Held until waitrequest is sampled low; the watchdog ends a hang
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    function automatic logic [15:0] pa(input logic [5:0] p,
                                       input logic [4:0] w);
        return {4'h0, p, w, 1'b0};
    endfunction
    task automatic cmd(input logic [7:0] code, input logic [15:0] ptr,
                       input logic [15:0] w, input logic [3:0] d);
        bus(1'b1, `FSPS_ADDR_POINTER, {16'h0, ptr});
        bus(1'b1, `FSPS_ADDR_DATA_LO, {24'h0, w[7:0]});
        bus(1'b1, `FSPS_ADDR_DATA_HI, {24'h0, w[15:8]});
        bus(1'b1, `FSPS_ADDR_CTRL, {24'h0, code});
        go <= 1'b1;
        dly <= d;
        @(posedge clk);
        go <= 1'b0;
        repeat (6) @(negedge clk);
        while (cpu_halt_r !== 1'b0) @(negedge clk);
    endtask
    task automatic stat_bit(input string nm, input logic e);
        bus(1'b0, `FSPS_ADDR_STATUS, 32'h0);
        chk(nm, q[`FSPS_STAT_BUF_USED], e);
    endtask

    // ========================================================
    // Scenarios
    task automatic t_basic;
        bus(1'b0, `FSPS_ADDR_STATUS, 32'h0);
        chk("status", q, 32'h0);
        bus(1'b1, 8'h20, 32'hFF);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 32'h0);
    endtask
    // Unchanged words ride in the buffer across the erase
    task automatic t_update;
        cmd(`FSPS_CODE_LOAD, pa(6'd5, 5'd3), 16'h1234, 4'h0);
        cmd(`FSPS_CODE_ERASE, 16'hF14F, 16'hBEEF, 4'h1);
        chk("erase count", ne, 1);
        chk("erase page", er_page, 32'h5);
        cmd(`FSPS_CODE_LOAD, pa(6'd5, 5'd31), 16'h00C3, 4'h1);
        cmd(`FSPS_CODE_LOAD, pa(6'd5, 5'd0), 16'hABCD, 4'h0);
        cmd(`FSPS_CODE_WRITE, pa(6'd5, 5'd0), 16'h5A5A, 4'h0);
        chk("prog count", nw, 32);
        chk("write page", wp_page, 32'h5);
        chk("word 0", seen[0], 16'hABCD);
        chk("word 3", seen[3], 16'h1234);
        chk("word 31", seen[31], 16'h00C3);
        chk("word 1", seen[1], `FSPS_ERASED_WORD);
        stat_bit("buf after write", 1'b0);
    endtask
    task automatic t_late;
        cmd(`FSPS_CODE_LOAD, pa(6'd1, 5'd2), 16'h7777, 4'h2);
        stat_bit("late load", 1'b0);
        bus(1'b0, `FSPS_ADDR_CTRL, 32'h0);
        chk("code cleared", q, 32'h0);
    endtask
    task automatic t_codes;
        logic [7:0] cs [4];
        cs = '{8'h02, 8'h04, 8'h07, 8'h09};
        foreach (cs[i]) cmd(cs[i], pa(6'd2, 5'd1), 16'h1111, 4'h0);
        stat_bit("other code buf", 1'b0);
        chk("other code erase", ne, 1);
        chk("other code prog", nw, 32);
    endtask
    task automatic t_eeprom;
        cmd(`FSPS_CODE_LOAD, pa(6'd3, 5'd4), 16'h4242, 4'h0);
        stat_bit("load flag", 1'b1);
        @(posedge clk);
        eeprom_busy <= 1'b1;
        cmd(`FSPS_CODE_ERASE, pa(6'd3, 5'd0), 16'h0, 4'h0);
        stat_bit("ee discard", 1'b0);
        chk("ee blocked", ne, 1);
        @(posedge clk);
        eeprom_busy <= 1'b0;
    endtask
    task automatic t_clears;
        cmd(`FSPS_CODE_LOAD, pa(6'd3, 5'd4), 16'h4343, 4'h0);
        bus(1'b1, `FSPS_ADDR_CTRL, 32'h10);
        stat_bit("reenable clear", 1'b0);
        cmd(`FSPS_CODE_LOAD, pa(6'd7, 5'd4), 16'h4444, 4'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        stat_bit("reset clear", 1'b0);
        cmd(`FSPS_CODE_WRITE, pa(6'd7, 5'd0), 16'h0, 4'h0);
        chk("word 4 empty", seen[4], `FSPS_ERASED_WORD);
    endtask

    // ========================================================
    // Run control
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #80000;
        fails++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        eeprom_busy = 1'b0;
        go = 1'b0;
        dly = 4'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_basic();
        t_update();
        t_late();
        t_codes();
        t_eeprom();
        t_clears();
        test_done();
    end
endmodule
`default_nettype wire
